// ===== include/fpar_defs.vh
// constants for the flash protection and addressing register group
`ifndef FPAR_DEFS_VH
`define FPAR_DEFS_VH
// command codes
`define FPAR_OP_RD_SUSP 8'h07
`define FPAR_OP_RD_BANK 8'h16
`define FPAR_OP_WR_BANK 8'h17
`define FPAR_OP_RD_PMS 8'h2B
`define FPAR_OP_PG_PMS 8'h2F
`define FPAR_OP_RD_PASS 8'hE7
`define FPAR_OP_PG_PASS 8'hE8
`define FPAR_OP_RD_LOCK 8'hA7
`define FPAR_OP_WR_LOCK 8'hA6
`define FPAR_OP_RD_PSEC 8'hE2
`define FPAR_OP_PG_PSEC 8'hE3
`define FPAR_OP_ER_PSEC 8'hE4
`define FPAR_OP_RD_DSEC 8'hE0
`define FPAR_OP_WR_DSEC 8'hE1
`define FPAR_OP_RD_NVTP 8'h41
`define FPAR_OP_PG_NVTP 8'h43
`define FPAR_OP_RD_VTP 8'h4A
`define FPAR_OP_WR_VTP 8'h4B
// field positions
`define FPAR_SUSP_ERASE_BIT 1
`define FPAR_SUSP_PROG_BIT 0
`define FPAR_BANK_EXT_BIT 7
`define FPAR_BANK_LOW_BIT 0
`define FPAR_PMS_PWD_BIT 2
`define FPAR_PMS_PST_BIT 1
`define FPAR_LOCK_BIT 0
// reset values
`define FPAR_BANK_RESET 8'h00
`define FPAR_PMS_RESET 16'hFE7F
`define FPAR_PASS_RESET 64'hFFFFFFFFFFFFFFFF
`define FPAR_SECT_RESET 1'b1
`define FPAR_NVTP_RESET 8'h00
`define FPAR_BYTE_PROT 8'h00
`define FPAR_BYTE_UNPROT 8'hFF
// sector geometry: 64 KB sectors over a 256 Mb array
`define FPAR_SECT_BITS 9
`define FPAR_SECT_CNT 512
`define FPAR_SECT_LSB 16
`define FPAR_ADDR3 4'h3
`define FPAR_ADDR4 4'h4
`endif

// ===== rtl/fpar_regs.v
// serial-command register group: suspend, bank, protection, password, sector, training
// Functional notes
// - erase-suspend flag at bit 1, reset zero
// - program-suspend flag at bit 0, reset zero
// - extended enable set means 32-bit addresses
// - extended clear: 24 bits plus bank bits
// - bank bit 0 gives A24; others reserved
// - clearing bit 2 locks password mode forever
// - clearing bit 1 locks persistent mode forever
// - 64-bit password hidden once password mode set
// - lock zero refuses persistent array changes
// - lock comes up one in persistent mode
// - persistent byte reads 00h protected, FFh not
// - dynamic byte written/read 00h or FFh
// - one-time training pattern, default 00h
// - volatile training copy loaded at reset
`include "fpar_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module fpar_regs (
  // clock and resets
  input wire core_clk,
  input wire srst,
  input wire pwr_rst,
  // serial pins
  input wire sck,
  input wire cs_n,
  input wire si,
  output reg so_r,
  output reg so_oe_r,
  // array controller status
  input wire erase_suspended_in,
  input wire program_suspended_in,
  // register state to the core
  output reg erase_suspended_flag_r,
  output reg program_suspended_flag_r,
  output reg four_byte_addr_enable_r,
  output reg bank_bit_low_r,
  output reg [15:0] protection_mode_select_r,
  output reg persistent_array_lock_bit_r,
  output reg [7:0] volatile_training_value_r
);

  // pin synchronisers: the first stage feeds only the second
  reg sck_m_r, sck_s_r, sck_d_r;
  reg cs_m_r, cs_s_r;
  reg si_m_r, si_s_r;
  always @(posedge core_clk) begin
    sck_m_r <= sck;
    sck_s_r <= sck_m_r;
    sck_d_r <= sck_s_r;
    cs_m_r <= cs_n;
    cs_s_r <= cs_m_r;
    si_m_r <= si;
    si_s_r <= si_m_r;
  end

  wire sck_rise = sck_s_r & ~sck_d_r & ~cs_s_r;
  wire sck_fall = ~sck_s_r & sck_d_r & ~cs_s_r;

  // non-volatile and one-time contents plus dynamic bits; power-up resets all, hardware reset only the dynamic bits
  reg [63:0] hidden_password_value_r;
  reg [7:0] nonvolatile_training_value_r;
  reg [`FPAR_SECT_CNT-1:0] persistent_sector_bit_r;
  reg [`FPAR_SECT_CNT-1:0] dynamic_sector_bit_r;

  // command engine
  reg [2:0] bitcnt_r;
  reg [3:0] bytecnt_r;
  reg [6:0] shreg_r;
  reg [7:0] opcode_r;
  reg [31:0] addr_r;
  reg [7:0] txsh_r;
  reg tx_en_r;

  wire [7:0] rx_byte = {shreg_r, si_s_r};
  wire byte_done = sck_rise & (bitcnt_r == 3'h7);
  wire [7:0] op_cur = (bytecnt_r == 4'h0) ? rx_byte : opcode_r;
  wire addressed = (op_cur == `FPAR_OP_RD_PSEC) | (op_cur == `FPAR_OP_PG_PSEC) |
                   (op_cur == `FPAR_OP_RD_DSEC) | (op_cur == `FPAR_OP_WR_DSEC);
  // 4 address bytes only when the extended enable is set
  wire [3:0] nab = addressed ? (four_byte_addr_enable_r ? `FPAR_ADDR4 : `FPAR_ADDR3) :
                   4'h0;
  wire in_addr = (bytecnt_r != 4'h0) & (bytecnt_r <= nab);
  wire [31:0] addr_nxt = in_addr ? {addr_r[23:0], rx_byte} : addr_r;
  // 3-byte mode: upper bits come from the bank field, bit 1 is reserved
  wire [31:0] eff_addr = four_byte_addr_enable_r ? addr_nxt :
                         {7'h00, bank_bit_low_r, addr_nxt[23:0]};
  wire [`FPAR_SECT_BITS-1:0] sect =
    eff_addr[`FPAR_SECT_LSB+`FPAR_SECT_BITS-1:`FPAR_SECT_LSB];
  wire [3:0] rd_idx = bytecnt_r - nab;
  wire [3:0] wr_idx = bytecnt_r - nab - 4'h1;
  wire rd_ok = (bytecnt_r >= nab);
  wire wr_ok = (bytecnt_r > nab);
  wire pwd_mode = ~protection_mode_select_r[`FPAR_PMS_PWD_BIT];

  // next byte to shift out
  reg [7:0] tx_byte;
  reg tx_valid;
  always @* begin
    tx_byte = 8'h00;
    tx_valid = rd_ok;
    case (op_cur)
      `FPAR_OP_RD_SUSP:
        tx_byte = {6'h00, erase_suspended_flag_r, program_suspended_flag_r};
      `FPAR_OP_RD_BANK:
        tx_byte = {four_byte_addr_enable_r, 6'h00, bank_bit_low_r};
      `FPAR_OP_RD_PMS:
        tx_byte = rd_idx[0] ? protection_mode_select_r[15:8] :
                  protection_mode_select_r[7:0];
      `FPAR_OP_RD_PASS:
        // hidden once password mode is chosen; all ones is returned instead
        tx_byte = pwd_mode ? 8'hFF : hidden_password_value_r[rd_idx[2:0]*8 +: 8];
      `FPAR_OP_RD_LOCK:
        tx_byte = {7'h00, persistent_array_lock_bit_r};
      `FPAR_OP_RD_PSEC:
        tx_byte = persistent_sector_bit_r[sect] ? `FPAR_BYTE_UNPROT :
                  `FPAR_BYTE_PROT;
      `FPAR_OP_RD_DSEC:
        tx_byte = dynamic_sector_bit_r[sect] ? `FPAR_BYTE_UNPROT :
                  `FPAR_BYTE_PROT;
      `FPAR_OP_RD_NVTP:
        tx_byte = nonvolatile_training_value_r;
      `FPAR_OP_RD_VTP:
        tx_byte = volatile_training_value_r;
      default:
        tx_valid = 1'b0;
    endcase
  end

  // serial framing and output shifting
  always @(posedge core_clk) begin
    if (srst | pwr_rst | cs_s_r) begin
      bitcnt_r <= 3'h0;
      bytecnt_r <= 4'h0;
      shreg_r <= 7'h00;
      opcode_r <= 8'h00;
      addr_r <= 32'h00000000;
      txsh_r <= 8'h00;
      tx_en_r <= 1'b0;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      if (sck_rise) begin
        shreg_r <= rx_byte[6:0];
        bitcnt_r <= bitcnt_r + 3'h1;
      end
      if (byte_done) begin
        if (bytecnt_r == 4'h0)
          opcode_r <= rx_byte;
        addr_r <= addr_nxt;
        // byte counter saturates so long reads keep repeating the last field
        if (bytecnt_r != 4'hF)
          bytecnt_r <= bytecnt_r + 4'h1;
        txsh_r <= tx_byte;
        tx_en_r <= tx_valid;
      end else if (sck_fall) begin
        so_r <= txsh_r[7];
        so_oe_r <= tx_en_r;
        txsh_r <= {txsh_r[6:0], 1'b0};
      end
    end
  end

  // suspend flags follow the array controller
  always @(posedge core_clk) begin
    if (srst | pwr_rst) begin
      erase_suspended_flag_r <= 1'b0;
      program_suspended_flag_r <= 1'b0;
    end else begin
      erase_suspended_flag_r <= erase_suspended_in;
      program_suspended_flag_r <= program_suspended_in;
    end
  end

  wire wr_cmd = byte_done & wr_ok;
  wire lock_open = persistent_array_lock_bit_r;
  localparam [7:0] BANK_RST = `FPAR_BANK_RESET;

  // volatile registers
  always @(posedge core_clk) begin
    if (srst | pwr_rst) begin
      four_byte_addr_enable_r <= BANK_RST[`FPAR_BANK_EXT_BIT];
      bank_bit_low_r <= 1'b0;
      // lock opens after reset unless the password gate is chosen
      persistent_array_lock_bit_r <= pwr_rst | ~pwd_mode;
      // volatile copy refreshed from the stored pattern on hardware reset, set to the 00h default on power-up reset
      volatile_training_value_r <= pwr_rst ? `FPAR_NVTP_RESET :
                                   nonvolatile_training_value_r;
    end else if (wr_cmd) begin
      case (opcode_r)
        `FPAR_OP_WR_BANK: begin
          four_byte_addr_enable_r <= rx_byte[`FPAR_BANK_EXT_BIT];
          bank_bit_low_r <= rx_byte[`FPAR_BANK_LOW_BIT];
        end
        `FPAR_OP_WR_LOCK:
          // only clearing is possible; the lock then holds until reset
          if (~rx_byte[`FPAR_LOCK_BIT])
            persistent_array_lock_bit_r <= 1'b0;
        `FPAR_OP_WR_VTP:
          volatile_training_value_r <= rx_byte;
        default: begin
        end
      endcase
    end
  end

  // one-time and non-volatile storage: programming only clears bits
  always @(posedge core_clk) begin
    if (pwr_rst) begin
      protection_mode_select_r <= `FPAR_PMS_RESET;
      hidden_password_value_r <= `FPAR_PASS_RESET;
      nonvolatile_training_value_r <= `FPAR_NVTP_RESET;
    end else if (wr_cmd) begin
      case (opcode_r)
        `FPAR_OP_PG_PMS:
          if (wr_idx == 4'h0) begin
            // reserved bits are kept; lock bits can only go to zero
            protection_mode_select_r[`FPAR_PMS_PWD_BIT] <=
              protection_mode_select_r[`FPAR_PMS_PWD_BIT] &
              rx_byte[`FPAR_PMS_PWD_BIT];
            protection_mode_select_r[`FPAR_PMS_PST_BIT] <=
              protection_mode_select_r[`FPAR_PMS_PST_BIT] &
              rx_byte[`FPAR_PMS_PST_BIT];
          end
        `FPAR_OP_PG_PASS:
          if (wr_idx < 4'h8 && !pwd_mode)
            hidden_password_value_r[wr_idx[2:0]*8 +: 8] <=
              hidden_password_value_r[wr_idx[2:0]*8 +: 8] & rx_byte;
        `FPAR_OP_PG_NVTP:
          if (wr_idx == 4'h0)
            nonvolatile_training_value_r <= nonvolatile_training_value_r & rx_byte;
        default: begin
        end
      endcase
    end
  end

  // per-sector protection bits
  wire addr_last = byte_done & addressed & (bytecnt_r == nab);
  wire op_first = byte_done & (bytecnt_r == 4'h0);
  genvar g;
  generate
    for (g = 0; g < `FPAR_SECT_CNT; g = g + 1) begin : g_sect
      wire hit = (sect == g);
      always @(posedge core_clk) begin
        if (pwr_rst)
          persistent_sector_bit_r[g] <= `FPAR_SECT_RESET;
        else if (lock_open & op_first & (rx_byte == `FPAR_OP_ER_PSEC))
          persistent_sector_bit_r[g] <= 1'b1;
        else if (lock_open & addr_last & hit & (opcode_r == `FPAR_OP_PG_PSEC))
          persistent_sector_bit_r[g] <= 1'b0;
      end
      always @(posedge core_clk) begin
        if (srst | pwr_rst)
          dynamic_sector_bit_r[g] <= `FPAR_SECT_RESET;
        else if (wr_cmd & hit & (opcode_r == `FPAR_OP_WR_DSEC) & (wr_idx == 4'h0)) begin
          // values other than 00h and FFh leave the bit alone
          if (rx_byte == `FPAR_BYTE_PROT)
            dynamic_sector_bit_r[g] <= 1'b0;
          else if (rx_byte == `FPAR_BYTE_UNPROT)
            dynamic_sector_bit_r[g] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== test/flash_protect_addr_regs_bench.sv
// self-checking bench for the flash protection register group
`include "fpar_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module flash_protect_addr_regs_bench;
  logic core_clk, srst, pwr_rst, erase_in, prog_in;
  wire sck, cs_n, si, so_r, so_oe_r, esf, psf, ext, bank0, lock;
  wire [15:0] pms;
  wire [7:0] vtp;
  logic [63:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  fpar_regs uut (.core_clk(core_clk), .srst(srst), .pwr_rst(pwr_rst), .sck(sck), .cs_n(cs_n),
    .si(si), .so_r(so_r), .so_oe_r(so_oe_r), .erase_suspended_in(erase_in),
    .program_suspended_in(prog_in), .erase_suspended_flag_r(esf),
    .program_suspended_flag_r(psf), .four_byte_addr_enable_r(ext), .bank_bit_low_r(bank0),
    .protection_mode_select_r(pms), .persistent_array_lock_bit_r(lock),
    .volatile_training_value_r(vtp));
  fpar_host host (.core_clk(core_clk), .so(so_r), .sck(sck), .cs_n(cs_n), .si(si));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic check(input string w, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic reg_rd(input logic [7:0] op, input int n, input logic [63:0] e);
    host.frame(op, 32'h0, 0, 64'h0, n, rd);
    check($sformatf("read %h", op), e, rd);
  endtask
  task automatic reg_wr(input logic [7:0] op, input int n, input logic [63:0] d);
    host.frame(op, 32'h0, 0, d, n, rd);
  endtask
  task automatic sec_rd(input logic [7:0] op, input logic [31:0] a, input int na,
      input logic [7:0] e);
    host.frame(op, a, na, 64'h0, 1, rd);
    check($sformatf("sector %h", a), {56'h0, e}, rd);
  endtask
  task automatic do_reset(input logic pw);
    srst <= 1'b1;
    pwr_rst <= pw;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    pwr_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // run is about 20k cycles; the limit leaves a wide margin
  initial begin
    #300000;
    fail_count++;
    give_verdict;
  end
  initial begin
    srst = 1'b1;
    pwr_rst = 1'b1;
    erase_in = 1'b0;
    prog_in = 1'b0;
    do_reset(1'b1);
    reg_rd(`FPAR_OP_RD_VTP, 1, 64'h00);
    erase_in <= 1'b1;
    reg_rd(`FPAR_OP_RD_SUSP, 1, 64'h02);
    erase_in <= 1'b0;
    prog_in <= 1'b1;
    reg_rd(`FPAR_OP_RD_SUSP, 1, 64'h01);
    prog_in <= 1'b0;
    reg_wr(`FPAR_OP_WR_BANK, 1, 64'hFF);
    reg_rd(`FPAR_OP_RD_BANK, 1, 64'h81);
    check("ext enable", 1, ext);
    host.frame(`FPAR_OP_WR_DSEC, 32'h0123_0000, 4, 64'h00, 1, rd);
    host.frame(`FPAR_OP_WR_DSEC, 32'h0124_0000, 4, 64'h5A, 1, rd);
    sec_rd(`FPAR_OP_RD_DSEC, 32'h0123_0000, 4, 8'h00);
    sec_rd(`FPAR_OP_RD_DSEC, 32'h0124_0000, 4, 8'hFF);
    reg_wr(`FPAR_OP_WR_BANK, 1, 64'h01);
    sec_rd(`FPAR_OP_RD_DSEC, 32'h0023_0000, 3, 8'h00);
    reg_wr(`FPAR_OP_WR_BANK, 1, 64'h00);
    sec_rd(`FPAR_OP_RD_DSEC, 32'h0023_0000, 3, 8'hFF);
    host.frame(`FPAR_OP_PG_PSEC, 32'h0005_0000, 3, 64'h0, 0, rd);
    sec_rd(`FPAR_OP_RD_PSEC, 32'h0005_0000, 3, 8'h00);
    sec_rd(`FPAR_OP_RD_PSEC, 32'h0006_0000, 3, 8'hFF);
    reg_wr(`FPAR_OP_WR_LOCK, 1, 64'h00);
    reg_rd(`FPAR_OP_RD_LOCK, 1, 64'h00);
    reg_wr(`FPAR_OP_ER_PSEC, 0, 64'h0);
    sec_rd(`FPAR_OP_RD_PSEC, 32'h0005_0000, 3, 8'h00);
    reg_wr(`FPAR_OP_PG_NVTP, 1, 64'h5A);
    reg_wr(`FPAR_OP_WR_VTP, 1, 64'hA5);
    reg_rd(`FPAR_OP_RD_VTP, 1, 64'hA5);
    do_reset(1'b0);
    reg_rd(`FPAR_OP_RD_LOCK, 1, 64'h01);
    reg_wr(`FPAR_OP_ER_PSEC, 0, 64'h0);
    sec_rd(`FPAR_OP_RD_PSEC, 32'h0005_0000, 3, 8'hFF);
    reg_wr(`FPAR_OP_WR_BANK, 1, 64'h01);
    sec_rd(`FPAR_OP_RD_DSEC, 32'h0023_0000, 3, 8'hFF);
    reg_rd(`FPAR_OP_RD_VTP, 1, 64'h00);
    reg_rd(`FPAR_OP_RD_NVTP, 1, 64'h00);
    check("training port", 64'h00, vtp);
    reg_rd(`FPAR_OP_RD_PASS, 8, 64'hFFFF_FFFF_FFFF_FFFF);
    reg_wr(`FPAR_OP_PG_PASS, 8, 64'h0123_4567_89AB_CDEF);
    reg_rd(`FPAR_OP_RD_PASS, 8, 64'h0123_4567_89AB_CDEF);
    reg_wr(`FPAR_OP_PG_PMS, 2, 64'h01FD);
    reg_rd(`FPAR_OP_RD_PMS, 2, 64'hFE7D);
    do_reset(1'b0);
    check("array lock", 1, lock);
    reg_wr(`FPAR_OP_PG_PMS, 2, 64'hFFFB);
    reg_rd(`FPAR_OP_RD_PMS, 2, 64'hFE79);
    reg_rd(`FPAR_OP_RD_PASS, 8, 64'hFFFF_FFFF_FFFF_FFFF);
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== test/fpar_host.sv
// serial host model driving register commands into the flash register group
`timescale 1ns/10ps
`default_nettype none
module fpar_host (
  // clock and returned data
  input wire logic core_clk,
  input wire logic so,
  // serial pins towards the device
  output logic sck,
  output logic cs_n,
  output logic si
);
  // mode 0: sck idles low and stands still between frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // 8 core cycles per phase, well above the 3 the synchroniser needs
  task automatic bit_x(input logic b, output logic r);
    sck <= 1'b0;
    si <= b;
    repeat (8) @(posedge core_clk);
    sck <= 1'b1;
    r = so;
    repeat (8) @(posedge core_clk);
  endtask
  // opcode, na address bytes msb first, nd data bytes (byte n in bits 8n+7..8n)
  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int na,
      input logic [63:0] wd, input int nd, output logic [63:0] rd);
    logic r;
    int i;
    int k;
    rd = '0;
    cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (k = 7; k >= 0; k--) bit_x(op[k], r);
    for (i = na - 1; i >= 0; i--) for (k = 7; k >= 0; k--) bit_x(ad[8 * i + k], r);
    for (i = 0; i < nd; i++) for (k = 7; k >= 0; k--) begin
      bit_x(wd[8 * i + k], r);
      rd[8 * i + k] = r;
    end
    sck <= 1'b0;
    repeat (8) @(posedge core_clk);
    cs_n <= 1'b1;
    // released data line must not keep showing the last bit
    si <= ~si;
    repeat (8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== test/fpar_regs_asserts.sv
// checker for the flash protection register group
`include "fpar_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module fpar_regs_asserts (
  // clock and resets
  input wire logic core_clk,
  input wire logic srst,
  input wire logic pwr_rst,
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_r,
  input wire logic so_oe_r,
  // status and register state
  input wire logic erase_suspended_in,
  input wire logic program_suspended_in,
  input wire logic erase_suspended_flag_r,
  input wire logic program_suspended_flag_r,
  input wire logic four_byte_addr_enable_r,
  input wire logic bank_bit_low_r,
  input wire logic [15:0] protection_mode_select_r,
  input wire logic persistent_array_lock_bit_r,
  input wire logic [7:0] volatile_training_value_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst || pwr_rst);
  // $past still sees reset-time values on the first edge after release
  sequence out_of_reset;
    !$past(srst) && !$past(pwr_rst);
  endsequence
  // pin cs_n high long enough that the synced frame is surely idle
  sequence frame_idle;
    cs_n [*8];
  endsequence
  erase_copy_a: assert property (
    out_of_reset |-> erase_suspended_flag_r == $past(erase_suspended_in))
    else $error("erase suspend flag does not follow its input");
  prog_copy_a: assert property (
    out_of_reset |-> program_suspended_flag_r == $past(program_suspended_in))
    else $error("program suspend flag does not follow its input");
  power_reset_a: assert property (
    $past(pwr_rst) |-> protection_mode_select_r == `FPAR_PMS_RESET
      && persistent_array_lock_bit_r && volatile_training_value_r == `FPAR_NVTP_RESET)
    else $error("wrong values after power reset");
  soft_reset_a: assert property (
    $past(srst) && !$past(pwr_rst) |-> !four_byte_addr_enable_r && !bank_bit_low_r
      && persistent_array_lock_bit_r == protection_mode_select_r[2])
    else $error("wrong values after hardware reset");
  otp_sticky_a: assert property (
    out_of_reset |-> (~$past(protection_mode_select_r[2:1]) & protection_mode_select_r[2:1]) == 2'h0)
    else $error("one-time mode lock returned to one");
  pms_reserved_a: assert property (
    protection_mode_select_r[15:3] == 13'h1FCF && protection_mode_select_r[0])
    else $error("reserved protection mode bits changed");
  lock_sticky_a: assert property (
    out_of_reset and !$past(persistent_array_lock_bit_r) |-> !persistent_array_lock_bit_r)
    else $error("array lock set again without reset");
  frame_quiet_a: assert property (
    frame_idle |=> $stable({four_byte_addr_enable_r, bank_bit_low_r, volatile_training_value_r}))
    else $error("volatile register changed outside a frame");
  oe_idle_a: assert property (
    frame_idle |-> !so_oe_r)
    else $error("serial output driven outside a frame");
endmodule
bind fpar_regs fpar_regs_asserts chk (.core_clk(core_clk), .srst(srst), .pwr_rst(pwr_rst),
  .sck(sck), .cs_n(cs_n), .si(si), .so_r(so_r), .so_oe_r(so_oe_r),
  .erase_suspended_in(erase_suspended_in), .program_suspended_in(program_suspended_in),
  .erase_suspended_flag_r(erase_suspended_flag_r),
  .program_suspended_flag_r(program_suspended_flag_r),
  .four_byte_addr_enable_r(four_byte_addr_enable_r), .bank_bit_low_r(bank_bit_low_r),
  .protection_mode_select_r(protection_mode_select_r),
  .persistent_array_lock_bit_r(persistent_array_lock_bit_r),
  .volatile_training_value_r(volatile_training_value_r));
`default_nettype wire
